// ---- rtl/isa_bridge_pkg.sv ----
// package for the isa bridge routing and decode register group
// assumes a 20 MHz pci clock and byte-wide configuration accesses
package isa_bridge_pkg;

   // configuration byte indices
   localparam logic [7:0] OFS_DISK_IRQ = 8'h43;
   localparam logic [7:0] OFS_PCI_IRQ_LO = 8'h44;
   localparam logic [7:0] OFS_PCI_IRQ_HI = 8'h45;
   localparam logic [7:0] OFS_TIMER_LO = 8'h46;
   localparam logic [7:0] OFS_TIMER_HI = 8'h47;
   localparam logic [7:0] OFS_DECODE = 8'h48;
   localparam logic [7:0] OFS_ROM_DECODE = 8'h49;
   localparam logic [7:0] OFS_HOLE_START = 8'h4A;
   localparam logic [7:0] OFS_HOLE_SIZE = 8'h4B;
   localparam logic [7:0] OFS_CLK_DIV = 8'h4C;

   // reset values
   localparam logic [7:0] RST_DISK_IRQ = 8'hEF;
   localparam logic [15:0] RST_PCI_IRQ = 16'h0000;
   localparam logic [15:0] RST_TIMER = 16'h0078;
   localparam logic [7:0] RST_DECODE = 8'h01;
   localparam logic [7:0] RST_ROM_DECODE = 8'h00;
   localparam logic [7:0] RST_HOLE_START = 8'h00;
   localparam logic [7:0] RST_HOLE_SIZE = 8'h00;
   localparam logic [2:0] RST_CLK_SEL = 3'h0;

   // field positions
   localparam int CHAN_W = 4;
   localparam int PCI_LINES = 4;
   localparam int IRQ_CHANNELS = 16;
   localparam int DISK_PRI = 0;
   localparam int DISK_SEC = 1;
   localparam int TIMER_EN_BIT = 0;
   localparam int TIMER_BASE_LSB = 2;
   localparam int TOM_LSB = 4;
   localparam int LOW_ROM_BIT = 3;
   localparam int VIDEO_BIT = 2;
   localparam int UPPER_BASE_BIT = 1;
   localparam int LOWEST_BIT = 0;
   localparam int HOLE_EN_BIT = 7;
   localparam int PULSE_BIT = 3;
   localparam int CLK_SEL_W = 3;

   // isa address regions below 1 MByte, decoded on address bits 19:17
   localparam logic [2:0] REGION_UPPER_BASE = 3'h4;
   localparam logic [2:0] REGION_VIDEO = 3'h5;
   localparam logic [2:0] REGION_ADDON = 3'h6;
   localparam logic [2:0] REGION_HIGH = 3'h7;

   // bus clock select codes and divisors
   localparam logic [2:0] CLK_SEL_DIV4 = 3'h0;
   localparam logic [2:0] CLK_SEL_DIV3 = 3'h1;
   localparam logic [2:0] CLK_SEL_DIV2 = 3'h2;
   localparam logic [2:0] CLK_SEL_DIV6 = 3'h4;
   localparam logic [2:0] CLK_SEL_DIV8 = 3'h5;
   localparam logic [3:0] DIVISOR_2 = 4'h2;
   localparam logic [3:0] DIVISOR_3 = 4'h3;
   localparam logic [3:0] DIVISOR_4 = 4'h4;
   localparam logic [3:0] DIVISOR_6 = 4'h6;
   localparam logic [3:0] DIVISOR_8 = 4'h8;

   // timing
   localparam int CLK_PERIOD_NS = 50;
   localparam int RESET_PULSE_NS = 1000000;
   localparam int RESET_PULSE_CYCLES = RESET_PULSE_NS / CLK_PERIOD_NS;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } cfg_req_type;

   typedef struct packed {
      logic valid;
      logic [15:0] addr;
   } io_req_type;

   typedef struct packed {
      logic valid;
      logic [31:0] addr;
   } isa_req_type;

   typedef enum logic {PULSE_IDLE, PULSE_ACTIVE} pulse_state_type;

   // channels 0, 1, 2, 8 and 13 carry no pci interrupt
   function automatic logic channel_routable(input logic [3:0] ch);
      logic ok;
      ok = 1'b1;
      unique case (ch)
         4'h0, 4'h1, 4'h2, 4'h8, 4'hD: ok = 1'b0;
         default: ok = 1'b1;
      endcase
      return ok;
   endfunction

   function automatic logic [3:0] divisor_of(input logic [2:0] sel);
      logic [3:0] d;
      d = DIVISOR_4;
      unique case (sel)
         CLK_SEL_DIV3: d = DIVISOR_3;
         CLK_SEL_DIV2: d = DIVISOR_2;
         CLK_SEL_DIV6: d = DIVISOR_6;
         CLK_SEL_DIV8: d = DIVISOR_8;
         default: d = DIVISOR_4;
      endcase
      return d;
   endfunction

endpackage

// ---- rtl/bus_clock_divider.sv ----
// divides the pci clock down to the isa bus clock
// assumes the select code may change at any time; a change restarts the period
`timescale 1ns/1ps
`default_nettype none
module bus_clock_divider (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic [isa_bridge_pkg::CLK_SEL_W-1:0] i_sel,
   output logic o_bclk
);
   import isa_bridge_pkg::*;

   logic [3:0] count;
   logic [3:0] divisor;
   logic [2:0] last_sel;

   // reserved codes fall back to divide by four
   assign divisor = divisor_of(i_sel);

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         count <= 4'h0;
         last_sel <= RST_CLK_SEL;
      end else begin
         last_sel <= i_sel;
         if (i_sel != last_sel || count >= divisor - 4'h1) begin
            count <= 4'h0;
         end else begin
            count <= count + 4'h1;
         end
      end
   end

   // odd divisors give a short high phase
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_bclk <= 1'b0;
      end else begin
         o_bclk <= (count < (divisor >> 1));
      end
   end

   a_count_bound: assert property (@(posedge i_clk) disable iff (i_srst)
      $stable(i_sel) |-> count < divisor)
      else $error("bus clock counter beyond divisor");

endmodule
`default_nettype wire

// ---- rtl/isa_bridge_routing_decode_regs.sv ----
// routing and isa-to-pci decode configuration registers of the bridge
// assumes byte-wide config accesses, one per cycle, and synchronous inputs
`timescale 1ns/1ps
`default_nettype none
module isa_bridge_routing_decode_regs #(
   parameter int RESET_PULSE_CYCLES = isa_bridge_pkg::RESET_PULSE_CYCLES
) (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire isa_bridge_pkg::cfg_req_type i_cfg,
   output logic [7:0] o_cfg_rdata,
   input wire logic i_non_x86_mode,
   input wire logic i_lower_rom_select_enable,
   input wire logic [1:0] i_disk_irq,
   input wire logic [isa_bridge_pkg::PCI_LINES-1:0] i_pci_int_n,
   output logic [isa_bridge_pkg::IRQ_CHANNELS-1:0] o_irq_to_pic,
   input wire isa_bridge_pkg::io_req_type i_pci_io,
   output logic o_timer_claim,
   input wire isa_bridge_pkg::isa_req_type i_isa_mem,
   output logic o_isa_forward,
   output logic o_pci_bus_reset_n,
   output logic o_isa_bus_reset_out,
   output logic o_bclk
);
   import isa_bridge_pkg::*;

   localparam int PULSE_CNT_W = $clog2(RESET_PULSE_CYCLES + 1);
   logic [7:0] disk_irq_routing;
   logic [15:0] pci_irq_routing;
   logic [15:0] timer_io_base;
   logic [7:0] isa_forward_decode_ctrl;
   logic [7:0] rom_decode_enable;
   logic [7:0] hole_start_address;
   logic [7:0] hole_size_enable;
   logic [2:0] bus_clock_select;
   logic [3:0] primary_disk_irq_channel;
   logic [3:0] secondary_disk_irq_channel;
   logic [13:0] timer_base_field;
   logic timer_enable_bit;
   logic [3:0] top_of_memory_field;
   logic low_rom_block_enable;
   logic video_block_enable;
   logic upper_base_block_enable;
   logic lowest_block_enable;
   logic [7:0] hole_start_field;
   logic [6:0] hole_size_field;
   logic hole_enable_bit;
   logic bus_reset_pulse_bit;
   pulse_state_type pulse_state;
   logic [PULSE_CNT_W-1:0] pulse_count;
   logic pulse_start;
   logic [IRQ_CHANNELS-1:0] next_irq;
   logic [7:0] next_rdata;
   logic next_forward;
   logic timer_hit;
   logic below_16m;
   logic in_hole;
   assign primary_disk_irq_channel = disk_irq_routing[TOM_LSB +: CHAN_W];
   assign secondary_disk_irq_channel = disk_irq_routing[0 +: CHAN_W];
   assign timer_base_field = timer_io_base[15:TIMER_BASE_LSB];
   assign timer_enable_bit = timer_io_base[TIMER_EN_BIT];
   assign top_of_memory_field = isa_forward_decode_ctrl[TOM_LSB +: CHAN_W];
   assign low_rom_block_enable = isa_forward_decode_ctrl[LOW_ROM_BIT];
   assign video_block_enable = isa_forward_decode_ctrl[VIDEO_BIT];
   assign upper_base_block_enable = isa_forward_decode_ctrl[UPPER_BASE_BIT];
   assign lowest_block_enable = isa_forward_decode_ctrl[LOWEST_BIT];
   assign hole_start_field = hole_start_address;
   assign hole_size_field = hole_size_enable[HOLE_EN_BIT-1:0];
   assign hole_enable_bit = hole_size_enable[HOLE_EN_BIT];
   assign bus_reset_pulse_bit = (pulse_state == PULSE_ACTIVE);
   // register writes
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         disk_irq_routing <= RST_DISK_IRQ;
         pci_irq_routing <= RST_PCI_IRQ;
      end else if (i_cfg.wr) begin
         if (i_cfg.addr == OFS_DISK_IRQ) begin
            disk_irq_routing <= i_cfg.wdata;
         end
         if (i_cfg.addr == OFS_PCI_IRQ_LO) begin
            pci_irq_routing[7:0] <= i_cfg.wdata;
         end
         if (i_cfg.addr == OFS_PCI_IRQ_HI) begin
            pci_irq_routing[15:8] <= i_cfg.wdata;
         end
      end
   end
   // low two address bits are not stored, so the base stays dword aligned
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         timer_io_base <= RST_TIMER;
      end else if (i_cfg.wr && i_cfg.addr == OFS_TIMER_LO) begin
         timer_io_base[7:0] <= {i_cfg.wdata[7:TIMER_BASE_LSB], 1'b0, i_cfg.wdata[TIMER_EN_BIT]};
      end else if (i_cfg.wr && i_cfg.addr == OFS_TIMER_HI) begin
         timer_io_base[15:8] <= i_cfg.wdata;
      end
   end
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         isa_forward_decode_ctrl <= RST_DECODE;
         rom_decode_enable <= RST_ROM_DECODE;
         hole_start_address <= RST_HOLE_START;
         hole_size_enable <= RST_HOLE_SIZE;
      end else if (i_cfg.wr) begin
         if (i_cfg.addr == OFS_DECODE) begin
            isa_forward_decode_ctrl <= i_cfg.wdata;
         end
         if (i_cfg.addr == OFS_ROM_DECODE) begin
            rom_decode_enable <= i_cfg.wdata;
         end
         if (i_cfg.addr == OFS_HOLE_START) begin
            hole_start_address <= i_cfg.wdata;
         end
         if (i_cfg.addr == OFS_HOLE_SIZE) begin
            hole_size_enable <= i_cfg.wdata;
         end
      end
   end
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         bus_clock_select <= RST_CLK_SEL;
      end else if (i_cfg.wr && i_cfg.addr == OFS_CLK_DIV) begin
         bus_clock_select <= i_cfg.wdata[CLK_SEL_W-1:0];
      end
   end
   // bus reset pulse; a write while a pulse runs does not restart it
   assign pulse_start = i_cfg.wr && i_cfg.addr == OFS_CLK_DIV && i_cfg.wdata[PULSE_BIT]
                        && i_non_x86_mode && pulse_state == PULSE_IDLE;
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         pulse_state <= PULSE_IDLE;
         pulse_count <= '0;
         o_isa_bus_reset_out <= 1'b0;
         o_pci_bus_reset_n <= 1'b1;
      end else begin
         unique case (pulse_state)
            PULSE_IDLE: begin
               if (pulse_start) begin
                  pulse_state <= PULSE_ACTIVE;
                  pulse_count <= PULSE_CNT_W'(RESET_PULSE_CYCLES);
                  o_isa_bus_reset_out <= 1'b1;
                  o_pci_bus_reset_n <= 1'b0;
               end
            end
            PULSE_ACTIVE: begin
               pulse_count <= pulse_count - 1'b1;
               if (pulse_count == PULSE_CNT_W'(1)) begin
                  pulse_state <= PULSE_IDLE;
                  o_isa_bus_reset_out <= 1'b0;
                  o_pci_bus_reset_n <= 1'b1;
               end
            end
         endcase
      end
   end
   // register reads; reserved bits read zero
   always_comb begin
      next_rdata = 8'h00;
      unique case (i_cfg.addr)
         OFS_DISK_IRQ: next_rdata = disk_irq_routing;
         OFS_PCI_IRQ_LO: next_rdata = pci_irq_routing[7:0];
         OFS_PCI_IRQ_HI: next_rdata = pci_irq_routing[15:8];
         OFS_TIMER_LO: next_rdata = timer_io_base[7:0];
         OFS_TIMER_HI: next_rdata = timer_io_base[15:8];
         OFS_DECODE: next_rdata = isa_forward_decode_ctrl;
         OFS_ROM_DECODE: next_rdata = rom_decode_enable;
         OFS_HOLE_START: next_rdata = hole_start_address;
         OFS_HOLE_SIZE: next_rdata = hole_size_enable;
         OFS_CLK_DIV: next_rdata = {4'h0, bus_reset_pulse_bit, bus_clock_select};
         default: next_rdata = 8'h00;
      endcase
   end
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_cfg_rdata <= 8'h00;
      end else begin
         o_cfg_rdata <= i_cfg.rd ? next_rdata : 8'h00;
      end
   end
   // interrupt steering; sources merge onto a channel by or
   always_comb begin
      next_irq = '0;
      if (i_disk_irq[DISK_PRI]) begin
         next_irq[primary_disk_irq_channel] = 1'b1;
      end
      if (i_disk_irq[DISK_SEC]) begin
         next_irq[secondary_disk_irq_channel] = 1'b1;
      end
      for (int i = 0; i < PCI_LINES; i++) begin
         if (!i_pci_int_n[i] && channel_routable(pci_irq_routing[i*CHAN_W +: CHAN_W])) begin
            next_irq[pci_irq_routing[i*CHAN_W +: CHAN_W]] = 1'b1;
         end
      end
   end
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_irq_to_pic <= '0;
      end else begin
         o_irq_to_pic <= next_irq;
      end
   end
   // timer is the only io claim this block makes
   assign timer_hit = i_pci_io.valid && timer_enable_bit
                      && i_pci_io.addr[15:TIMER_BASE_LSB] == timer_base_field;
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_timer_claim <= 1'b0;
      end else begin
         o_timer_claim <= timer_hit;
      end
   end
   // isa master memory forwarding
   assign below_16m = (i_isa_mem.addr[31:24] == 8'h00);
   assign in_hole = below_16m && (((i_isa_mem.addr[23:16] ^ hole_start_field)
                    & ~{1'b0, hole_size_field}) == 8'h00);
   always_comb begin
      next_forward = 1'b0;
      if (!below_16m) begin
         next_forward = 1'b1;
      end else if (i_isa_mem.addr[23:20] != 4'h0) begin
         next_forward = (i_isa_mem.addr[23:20] <= top_of_memory_field);
      end else if (!i_isa_mem.addr[19]) begin
         next_forward = lowest_block_enable;
      end else begin
         unique case (i_isa_mem.addr[19:17])
            REGION_UPPER_BASE: next_forward = upper_base_block_enable;
            REGION_VIDEO: next_forward = video_block_enable;
            REGION_ADDON: next_forward = rom_decode_enable[i_isa_mem.addr[16:14]];
            REGION_HIGH: next_forward = !i_isa_mem.addr[16] && low_rom_block_enable
                                        && !i_lower_rom_select_enable;
            default: next_forward = 1'b0;
         endcase
      end
      if (hole_enable_bit && in_hole) begin
         next_forward = 1'b0;
      end
   end
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_isa_forward <= 1'b0;
      end else begin
         o_isa_forward <= i_isa_mem.valid && next_forward;
      end
   end
   bus_clock_divider bclk_gen (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .i_sel(bus_clock_select),
      .o_bclk(o_bclk)
   );
   // checking helpers
   logic disk_hits_13;
   logic [PULSE_CNT_W:0] high_run;
   assign disk_hits_13 = (i_disk_irq[DISK_PRI] && primary_disk_irq_channel == 4'hD)
                         || (i_disk_irq[DISK_SEC] && secondary_disk_irq_channel == 4'hD);
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         high_run <= '0;
      end else begin
         high_run <= o_isa_bus_reset_out ? high_run + 1'b1 : '0;
      end
   end
   sequence pulse_requested;
      pulse_start;
   endsequence
   sequence pulse_holds;
      (o_isa_bus_reset_out && !o_pci_bus_reset_n && bus_reset_pulse_bit) [*8];
   endsequence
   a_primary_route: assert property (@(posedge i_clk) disable iff (i_srst)
      i_disk_irq[DISK_PRI] |=> o_irq_to_pic[$past(primary_disk_irq_channel)])
      else $error("primary disk interrupt not routed");
   a_secondary_route: assert property (@(posedge i_clk) disable iff (i_srst)
      i_disk_irq[DISK_SEC] |=> o_irq_to_pic[$past(secondary_disk_irq_channel)])
      else $error("secondary disk interrupt not routed");
   a_line_a_route: assert property (@(posedge i_clk) disable iff (i_srst)
      !i_pci_int_n[PCI_LINES-1] && channel_routable(pci_irq_routing[15:12])
      |=> o_irq_to_pic[$past(pci_irq_routing[15:12])])
      else $error("pci line a not routed");
   a_reserved_quiet: assert property (@(posedge i_clk) disable iff (i_srst)
      o_irq_to_pic[13] |-> $past(disk_hits_13))
      else $error("reserved channel driven by a pci line");
   a_timer_claim: assert property (@(posedge i_clk) disable iff (i_srst)
      o_timer_claim |-> $past(timer_enable_bit) && $past(i_pci_io.valid))
      else $error("timer claimed while disabled");
   a_timer_base: assert property (@(posedge i_clk) disable iff (i_srst)
      i_pci_io.valid && timer_enable_bit && i_pci_io.addr[15:2] == timer_io_base[15:2]
      |=> o_timer_claim)
      else $error("timer base access not claimed");
   a_lowest_block: assert property (@(posedge i_clk) disable iff (i_srst)
      i_isa_mem.valid && i_isa_mem.addr < 32'h0008_0000 && lowest_block_enable && !hole_enable_bit
      |=> o_isa_forward)
      else $error("lowest block access not forwarded");
   a_above_16m: assert property (@(posedge i_clk) disable iff (i_srst)
      i_isa_mem.valid && i_isa_mem.addr >= 32'h0100_0000 |=> o_isa_forward)
      else $error("access above 16 MByte not forwarded");
   a_hole_blocks: assert property (@(posedge i_clk) disable iff (i_srst)
      i_isa_mem.valid && hole_enable_bit && in_hole |=> !o_isa_forward)
      else $error("hole access forwarded");
   a_rom_override: assert property (@(posedge i_clk) disable iff (i_srst)
      i_isa_mem.valid && i_lower_rom_select_enable && i_isa_mem.addr[31:16] == 16'h000E
      |=> !o_isa_forward)
      else $error("low rom forwarded despite chip select");
   a_pulse_start: assert property (@(posedge i_clk) disable iff (i_srst)
      pulse_requested |=> pulse_holds)
      else $error("bus reset pulse did not start");
   a_pulse_length: assert property (@(posedge i_clk) disable iff (i_srst)
      $fell(o_isa_bus_reset_out) |-> $past(high_run) == (PULSE_CNT_W+1)'(RESET_PULSE_CYCLES - 1))
      else $error("bus reset pulse length wrong");

endmodule
`default_nettype wire

// ---- testbench/host_model.sv ----
// host and isa master model: config, io and memory requests
// assumes the bench owns clock and reset and calls the tasks
`timescale 1ns/1ps
`default_nettype none
module host_model (
   input wire logic i_clk,
   output var isa_bridge_pkg::cfg_req_type o_cfg,
   output var isa_bridge_pkg::io_req_type o_io,
   output var isa_bridge_pkg::isa_req_type o_mem
);
   import isa_bridge_pkg::*;
   initial begin
      o_cfg = '0;
      o_io = '0;
      o_mem = '0;
   end
   // one strobe per call, dropped at the edge that takes it
   task automatic cfg(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      o_cfg <= '{wr: w, rd: !w, addr: a, wdata: d};
      @(posedge i_clk);
      o_cfg <= '0;
      #1;
   endtask
   // released address is inverted so no stale value lingers
   task automatic io(input logic [15:0] a);
      @(posedge i_clk);
      o_io <= '{valid: 1'b1, addr: a};
      @(posedge i_clk);
      o_io <= '{valid: 1'b0, addr: ~a};
      #1;
   endtask
   task automatic mem(input logic [31:0] a);
      @(posedge i_clk);
      o_mem <= '{valid: 1'b1, addr: a};
      @(posedge i_clk);
      o_mem <= '{valid: 1'b0, addr: ~a};
      #1;
   endtask
endmodule
`default_nettype wire

// ---- testbench/isa_bridge_routing_decode_regs_bench.sv ----
// self-checking bench for the routing and decode registers
// assumes the host model drives all bus requests
`timescale 1ns/1ps
`default_nettype none
module isa_bridge_routing_decode_regs_bench;
   import isa_bridge_pkg::*;
   localparam int PULSE = 10;
   localparam int code_tab [6] = '{0, 1, 2, 4, 5, 3};
   localparam int div_tab [6] = '{4, 3, 2, 6, 8, 4};
   logic i_clk = 0;
   logic i_srst = 1;
   logic non_x86 = 0;
   logic rom_sel = 0;
   logic [1:0] disk = '0;
   logic [3:0] pint_n = 4'hF;
   cfg_req_type cfg;
   io_req_type io;
   isa_req_type mem;
   logic [7:0] rdata;
   logic [15:0] irq;
   logic claim, fwd_out, pci_rst_n, isa_rst, bclk;
   int n_fail = 0;
   int checks = 0;
   int cycles = 0;
   always #25 i_clk = ~i_clk;
   host_model p (.i_clk(i_clk), .o_cfg(cfg), .o_io(io), .o_mem(mem));
   isa_bridge_routing_decode_regs #(.RESET_PULSE_CYCLES(PULSE)) i_dut (
      .i_clk(i_clk), .i_srst(i_srst), .i_cfg(cfg), .o_cfg_rdata(rdata),
      .i_non_x86_mode(non_x86), .i_lower_rom_select_enable(rom_sel),
      .i_disk_irq(disk), .i_pci_int_n(pint_n), .o_irq_to_pic(irq),
      .i_pci_io(io), .o_timer_claim(claim), .i_isa_mem(mem),
      .o_isa_forward(fwd_out), .o_pci_bus_reset_n(pci_rst_n),
      .o_isa_bus_reset_out(isa_rst), .o_bclk(bclk));
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      checks++;
      if (s !== e) begin
         n_fail++;
         $display("ERROR %s expected %0h seen %0h", n, e, s);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      p.cfg(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      p.cfg(1'b0, a, 8'h00);
      chk("cfg read", e, rdata);
   endtask
   task automatic fwd(input logic [31:0] a, input logic e);
      p.mem(a);
      chk("isa forward", e, fwd_out);
   endtask
   task automatic tclaim(input logic [15:0] a, input logic e);
      p.io(a);
      chk("timer claim", e, claim);
   endtask
   task automatic irqs(input logic [1:0] d, input logic [3:0] n, input logic [15:0] e);
      @(posedge i_clk);
      disk <= d;
      pint_n <= n;
      @(posedge i_clk);
      #1;
      chk("irq out", e, irq);
   endtask
   task automatic t_reset();
      rd(8'h43, 8'hEF);
      rd(8'h44, 8'h00);
      rd(8'h45, 8'h00);
      rd(8'h46, 8'h78);
      rd(8'h47, 8'h00);
      rd(8'h48, 8'h01);
      rd(8'h4A, 8'h00);
      rd(8'h4B, 8'h00);
      rd(8'h4C, 8'h00);
      rd(8'h50, 8'h00);
   endtask
   task automatic t_irq();
      irqs(2'b01, 4'hF, 16'h4000);
      irqs(2'b10, 4'hF, 16'h8000);
      wr(8'h43, 8'h35);
      irqs(2'b11, 4'hF, 16'h0028);
      wr(8'h45, 8'h58);
      wr(8'h44, 8'h9D);
      irqs(2'b00, 4'h0, 16'h0220);
      irqs(2'b00, 4'h7, 16'h0020);
      wr(8'h45, 8'h12);
      wr(8'h44, 8'hA0);
      irqs(2'b00, 4'h0, 16'h0400);
      irqs(2'b00, 4'hF, 16'h0000);
   endtask
   task automatic t_timer();
      tclaim(16'h0078, 1'b0);
      wr(8'h46, 8'hFF);
      rd(8'h46, 8'hFD);
      wr(8'h46, 8'h79);
      tclaim(16'h0078, 1'b1);
      tclaim(16'h007C, 1'b0);
      tclaim(16'h0410, 1'b0);
      wr(8'h47, 8'h12);
      tclaim(16'h1278, 1'b1);
      tclaim(16'h0078, 1'b0);
   endtask
   task automatic t_decode();
      fwd(32'h00000, 1'b1);
      fwd(32'h80000, 1'b0);
      fwd(32'h100000, 1'b0);
      fwd(32'h1000000, 1'b1);
      wr(8'h48, 8'h16);
      fwd(32'h00000, 1'b0);
      fwd(32'h80000, 1'b1);
      fwd(32'hA0000, 1'b1);
      fwd(32'h1FFFFF, 1'b1);
      fwd(32'h200000, 1'b0);
      fwd(32'hE0000, 1'b0);
      wr(8'h48, 8'h1E);
      fwd(32'hE0000, 1'b1);
      @(posedge i_clk);
      rom_sel <= 1'b1;
      fwd(32'hE0000, 1'b0);
      @(posedge i_clk);
      rom_sel <= 1'b0;
      wr(8'h49, 8'h01);
      fwd(32'hC0000, 1'b1);
      fwd(32'hC4000, 1'b0);
      wr(8'h4A, 8'h10);
      wr(8'h4B, 8'h01);
      fwd(32'h110000, 1'b1);
      wr(8'h4B, 8'h81);
      rd(8'h4A, 8'h10);
      fwd(32'h110000, 1'b0);
      fwd(32'h120000, 1'b1);
      wr(8'h4B, 8'h87);
      fwd(32'h170000, 1'b0);
      fwd(32'h180000, 1'b1);
   endtask
   task automatic t_clock();
      logic last;
      int n;
      for (int k = 0; k < 6; k++) begin
         wr(8'h4C, 8'(code_tab[k]));
         // a select change restarts the count; skip the odd first period
         repeat (2) @(posedge i_clk);
         #1;
         last = bclk;
         n = -1;
         for (int j = 0; j < 40; j++) begin
            @(posedge i_clk);
            #1;
            if (n >= 0) n++;
            if (!last && bclk) begin
               if (n > 0) break;
               n = 0;
            end
            last = bclk;
         end
         chk("bclk period", div_tab[k], n);
      end
   endtask
   task automatic t_pulse();
      int ni, np;
      wr(8'h4C, 8'h08);
      chk("isa reset", 1'b0, isa_rst);
      rd(8'h4C, 8'h00);
      @(posedge i_clk);
      non_x86 <= 1'b1;
      wr(8'h4C, 8'h08);
      ni = 0;
      np = 0;
      repeat (30) begin
         ni += int'(isa_rst === 1'b1);
         np += int'(pci_rst_n === 1'b0);
         @(posedge i_clk);
         #1;
      end
      chk("isa reset cycles", PULSE, ni);
      chk("pci reset cycles", PULSE, np);
      rd(8'h4C, 8'h00);
      wr(8'h4C, 8'h08);
      rd(8'h4C, 8'h08);
      repeat (20) @(posedge i_clk);
   endtask
   task automatic test_done();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // ceiling well above the roughly 300 cycles the tests need
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_fail++;
         $display("ERROR timeout expected 0 seen %0d", cycles);
         test_done();
      end
   end
   initial begin
      repeat (12) @(posedge i_clk);
      i_srst <= 1'b0;
      t_reset();
      t_irq();
      t_timer();
      t_decode();
      t_clock();
      t_pulse();
      test_done();
   end
endmodule
`default_nettype wire
